// >>> rtl/sweep_cfg.svh
`ifndef SWEEP_CFG_SVH
`define SWEEP_CFG_SVH
// Register addresses
`define ADDR_INIT_CONTROL 8'h01
`define ADDR_SYSTEM_ACTIVE 8'h02
`define ADDR_SYNTH_LOOP 8'h03
`define ADDR_OUTPUT_SELECT 8'h04
`define ADDR_SEQ_CONFIG 8'h05
`define ADDR_START_FREQ 8'h06
`define ADDR_STOP_FREQ 8'h07
`define ADDR_STEP_FREQ 8'h08
`define ADDR_DWELL_TIME 8'h09
`define ADDR_REPEAT_COUNT 8'h0a
// Data lengths in bytes
`define LEN_BYTE_REG 3'd1
`define LEN_FREQ_REG 3'd5
`define LEN_WORD_REG 3'd4
// Field positions in the sequence config
`define SEQ_RETURN_TO_START_BIT 5
`define SEQ_HW_TRIGGER_BIT 4
// Dwell unit in microseconds
`define DWELL_UNIT_US 500
// Reset value of every register
`define REG_RESET_VALUE 40'h00_0000_0000
`endif

// >>> rtl/sweep_pkg.sv
package sweep_pkg;
    // Serial framing states
    typedef enum logic [0:0] {
        WAIT_ADDR,
        TAKE_DATA
    } frame_state_t;
    typedef logic [39:0] freq_hz_t;
endpackage

// >>> rtl/byte_frame_if.sv
`timescale 1ns/1ps
interface byte_frame_if;
    logic [7:0] data; // Byte on the wire
    logic valid; // Byte present this cycle
    logic [7:0] addr; // Latched register address
    logic [2:0] len; // Data bytes expected
    modport framer (input data, input valid, input addr, output len);
    modport bank (output data, output valid, output addr, input len);
endinterface

// >>> rtl/reg_len_decode.sv
`timescale 1ns/1ps
`include "sweep_cfg.svh"
module reg_len_decode (
    byte_frame_if.framer link // Address to length lookup
);
    // Each register has a fixed length; unknown addresses take one byte
    always_comb begin
        if (link.addr == `ADDR_START_FREQ || link.addr == `ADDR_STOP_FREQ ||
            link.addr == `ADDR_STEP_FREQ) begin
            link.len = `LEN_FREQ_REG;
        end else if (link.addr == `ADDR_DWELL_TIME ||
                     link.addr == `ADDR_REPEAT_COUNT) begin
            link.len = `LEN_WORD_REG;
        end else begin
            link.len = `LEN_BYTE_REG;
        end
    end
endmodule

// >>> rtl/sweep_config_register_writes.sv
`timescale 1ns/1ps
`include "sweep_cfg.svh"
module sweep_config_register_writes #(
    parameter int LANES = `LEN_FREQ_REG, // Byte lanes in the widest register
    parameter int DWELL_UNIT = `DWELL_UNIT_US // Microseconds per dwell count
) (
    input wire logic clk, // 250 MHz clock
    input wire logic arst_n, // Async reset, active low
    input wire logic [7:0] rx_byte, // Received serial byte
    input wire logic rx_valid, // Byte strobe, one cycle
    output logic [7:0] init_control, // Initialise register
    output logic [7:0] system_active_indicator, // Active indicator
    output logic [7:0] synthesizer_loop_config, // Loop mode
    output logic [7:0] output_tone_or_sweep_select, // Output mode
    output logic [7:0] sweep_sequence_config, // Sweep config
    output sweep_pkg::freq_hz_t sweep_start_frequency, // Start in Hz
    output sweep_pkg::freq_hz_t sweep_stop_frequency, // Stop in Hz
    output sweep_pkg::freq_hz_t sweep_step_frequency, // Step in Hz
    output logic [31:0] point_dwell_time, // Dwell in 500 us units
    output logic [31:0] sweep_repeat_count, // Repeats, zero forever
    output logic return_to_start, // Cycle ends at start point
    output logic hw_trigger_sel, // Hardware trigger chosen
    output logic repeat_forever, // Endless repetition
    output logic [31:0] dwell_us_low, // Dwell in microseconds, low bits
    output logic write_done // Frame complete, one cycle, also for an unknown address
);
    // Refuse settings the datapath cannot serve: the lanes must fill the
    // 40-bit word exactly, and a dwell unit of zero would hide every dwell value
    if (LANES * 8 != $bits(sweep_pkg::freq_hz_t)) begin : g_bad_lanes
        $error("LANES must fill the frequency word exactly");
    end
    if (DWELL_UNIT < 1) begin : g_bad_unit
        $error("DWELL_UNIT must be at least one");
    end

    // Frame format, one byte per strobe, no gaps required:
    //   byte 0      register address
    //   byte 1..n   data, lowest lane first, n fixed per address
    //   byte n+1    next address, straight after
    // Nothing on the wire marks the end of a frame; the length table is
    // the only framing, so the host must send exactly n bytes
    byte_frame_if link (); // Framer to length lookup
    assign link.data = rx_byte;
    assign link.valid = rx_valid;

    // Length table, one entry per register address
    reg_len_decode u_len (
        .link(link)
    );

    sweep_pkg::frame_state_t state, next_state; // Frame position
    logic [7:0] addr, next_addr; // Address being written
    logic [2:0] count, next_count; // Data bytes received
    logic [39:0] shift, next_shift; // Assembly of data bytes
    logic commit; // Last byte landed
    logic [39:0] word; // Assembled value incl. last byte
    logic [39:0] lane_word; // Partial value with the new byte placed
    assign link.addr = addr;

    // One step per byte lane: the lane matching the byte count takes the
    // incoming byte, the others keep what earlier bytes left there
    for (genvar k = 0; k < LANES; k++) begin : g_lane
        assign lane_word[8*k +: 8] =
            (count == 3'(k)) ? link.data : shift[8*k +: 8];
    end

    // Framing: no byte counter resync exists, so a short or long write shifts later
    // frames until a reset or host filler bytes; this is the intended lost-framing model
    always_comb begin
        next_state = state;
        next_addr = addr;
        next_count = count;
        next_shift = shift;
        commit = 1'b0;
        word = shift;
        // Two phases: address, then a fixed run of data bytes
        case (state)
            sweep_pkg::WAIT_ADDR: begin
                // Any byte here is taken as an address, even an unknown one
                if (link.valid) begin
                    next_addr = link.data;
                    // Fresh frame: empty count and assembly
                    next_count = 3'd0;
                    next_shift = 40'h00_0000_0000;
                    next_state = sweep_pkg::TAKE_DATA;
                end
            end
            default: begin
                // Data phase: idle cycles between bytes are allowed
                if (link.valid) begin
                    // Byte k lands in lane k, lowest first
                    word = lane_word;
                    next_shift = word;
                    next_count = count + 3'd1;
                    // Length reached: commit; a wrong host count is not
                    // seen here and shifts later frames until a reset or filler bytes
                    if (next_count == link.len) begin
                        commit = 1'b1;
                        next_state = sweep_pkg::WAIT_ADDR;
                    end
                end
            end
        endcase
    end

    // Frame state registers; after a bad count this reset, or filler bytes from a
    // host that tracks the count, bring the framer back to a known address phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= sweep_pkg::WAIT_ADDR;
            addr <= 8'h00;
            count <= 3'd0;
            shift <= 40'h00_0000_0000;
        end else begin
            state <= next_state;
            addr <= next_addr;
            count <= next_count;
            shift <= next_shift;
        end
    end

    // Next values of the bank, one per register
    logic [7:0] next_init, next_active, next_loop, next_sel, next_seq;
    logic [39:0] next_start, next_stop, next_step;
    logic [31:0] next_dwell, next_repeat;

    // Register write decode; unknown addresses store nothing but still pulse write_done
    always_comb begin
        next_init = init_control;
        next_active = system_active_indicator;
        next_loop = synthesizer_loop_config;
        next_sel = output_tone_or_sweep_select;
        next_seq = sweep_sequence_config;
        next_start = sweep_start_frequency;
        next_stop = sweep_stop_frequency;
        next_step = sweep_step_frequency;
        next_dwell = point_dwell_time;
        next_repeat = sweep_repeat_count;
        // Only writes exist; nothing here can drive a value back out
        if (commit) begin
            // One-byte control registers take lane 0 only
            if (addr == `ADDR_INIT_CONTROL) begin
                next_init = word[7:0];
            end else if (addr == `ADDR_SYSTEM_ACTIVE) begin
                next_active = word[7:0];
            end else if (addr == `ADDR_SYNTH_LOOP) begin
                next_loop = word[7:0];
            end else if (addr == `ADDR_OUTPUT_SELECT) begin
                next_sel = word[7:0];
            end else if (addr == `ADDR_SEQ_CONFIG) begin
                next_seq = word[7:0];
            end else if (addr == `ADDR_START_FREQ) begin
                // Hertz words keep all five lanes
                next_start = word;
            end else if (addr == `ADDR_STOP_FREQ) begin
                next_stop = word;
            end else if (addr == `ADDR_STEP_FREQ) begin
                next_step = word;
            end else if (addr == `ADDR_DWELL_TIME) begin
                // Four-byte words drop the unused top lane
                next_dwell = word[31:0];
            end else if (addr == `ADDR_REPEAT_COUNT) begin
                next_repeat = word[31:0];
            end else begin
                // Unknown address: byte swallowed, nothing stored
            end
        end
    end

    // Register bank; reset values are our own, all zero
    // write_done rises on the same edge as the register it reports, so a
    // watcher can sample both together
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            init_control <= 8'h00;
            system_active_indicator <= 8'h00;
            synthesizer_loop_config <= 8'h00;
            output_tone_or_sweep_select <= 8'h00;
            sweep_sequence_config <= 8'h00;
            sweep_start_frequency <= `REG_RESET_VALUE;
            sweep_stop_frequency <= `REG_RESET_VALUE;
            sweep_step_frequency <= `REG_RESET_VALUE;
            point_dwell_time <= 32'h0000_0000;
            sweep_repeat_count <= 32'h0000_0000;
            write_done <= 1'b0;
        end else begin
            init_control <= next_init;
            system_active_indicator <= next_active;
            synthesizer_loop_config <= next_loop;
            output_tone_or_sweep_select <= next_sel;
            sweep_sequence_config <= next_seq;
            sweep_start_frequency <= next_start;
            sweep_stop_frequency <= next_stop;
            sweep_step_frequency <= next_step;
            point_dwell_time <= next_dwell;
            sweep_repeat_count <= next_repeat;
            write_done <= commit;
        end
    end

    // Decoded views for the sequencing engine; combinational from the
    // registers, so they change on the same edge as the write lands
    assign return_to_start =
        sweep_sequence_config[`SEQ_RETURN_TO_START_BIT];
    // Trigger source select
    assign hw_trigger_sel = sweep_sequence_config[`SEQ_HW_TRIGGER_BIT];
    // Zero count asks for endless repetition
    assign repeat_forever = (sweep_repeat_count == 32'h0000_0000);
    // Low 32 bits only; long dwells wrap, engine should use the count
    assign dwell_us_low = 32'(point_dwell_time * DWELL_UNIT);
endmodule

// >>> verif/host_byte_source.sv
`timescale 1ns/1ps
// Host side of the serial link, after byte recovery
module host_byte_source (
    input wire logic clk, // Bench clock
    output logic [7:0] rx_byte, // Byte to device
    output logic rx_valid // One-cycle strobe
);
    initial begin
        rx_byte = 8'h00;
        rx_valid = 1'b0;
    end
    // Drive on the falling edge, taken at the next rising edge
    task automatic put(input logic [7:0] b);
        @(negedge clk);
        rx_valid = 1'b1;
        rx_byte = b;
    endtask
    // Idle line shows the inverse, so a stale byte never looks valid
    task automatic idle();
        @(negedge clk);
        rx_valid = 1'b0;
        rx_byte = ~rx_byte;
    endtask
    // Address first, then n data bytes, lowest lane first
    task automatic frame(input logic [7:0] a, input logic [39:0] v,
                         input int n);
        put(a);
        for (int k = 0; k < n; k++) put(v[8*k+:8]);
        idle();
    endtask
endmodule

// >>> verif/sweep_config_register_writes_asserts.sv
`timescale 1ns/1ps
// Port-level watcher of the register bank
module sweep_config_register_writes_asserts (
    input wire logic clk, // Clock
    input wire logic arst_n, // Async reset, active low
    input wire logic [7:0] rx_byte, // Received byte
    input wire logic rx_valid, // Byte strobe
    input wire logic [7:0] sweep_sequence_config, // Sweep config
    input wire sweep_pkg::freq_hz_t sweep_start_frequency, // Start in Hz
    input wire logic [31:0] point_dwell_time, // Dwell count
    input wire logic [31:0] sweep_repeat_count, // Repeat count
    input wire logic return_to_start, // Bit 5 view
    input wire logic hw_trigger_sel, // Bit 4 view
    input wire logic repeat_forever, // Zero count flag
    input wire logic [31:0] dwell_us_low, // Dwell in microseconds
    input wire logic write_done // Commit pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Shortest frame is two bytes, so a pulse never repeats at once
    AST_DONE_PULSE: assert property (write_done |=> !write_done)
        else $error("write_done held two cycles");
    AST_DONE_CAUSE: assert property (write_done |-> $past(rx_valid))
        else $error("write_done without a byte");
    AST_RET_BIT: assert property (
        return_to_start == sweep_sequence_config[5])
        else $error("return_to_start wrong");
    AST_HW_BIT: assert property (
        hw_trigger_sel == sweep_sequence_config[4])
        else $error("hw_trigger_sel wrong");
    AST_FOREVER: assert property (
        repeat_forever == (sweep_repeat_count == 32'h0000_0000))
        else $error("repeat_forever wrong");
    AST_DWELL_US: assert property (
        dwell_us_low == 32'(point_dwell_time * 500))
        else $error("dwell_us_low wrong");
    // Top lane is the last byte taken, on the commit edge
    AST_START_TOP: assert property (
        $changed(sweep_start_frequency) |-> write_done
        && sweep_start_frequency[39:32] == $past(rx_byte))
        else $error("start frequency top lane wrong");
    AST_DWELL_TOP: assert property (
        $changed(point_dwell_time) |-> write_done
        && point_dwell_time[31:24] == $past(rx_byte))
        else $error("dwell top lane wrong");
    AST_COV_WRITE: cover property (write_done);
    AST_COV_FINITE: cover property ($fell(repeat_forever));
    AST_COV_HW: cover property (hw_trigger_sel && !return_to_start);
endmodule
bind sweep_config_register_writes sweep_config_register_writes_asserts
    i_sweep_config_register_writes_asserts (
    .clk(clk),
    .arst_n(arst_n),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid),
    .sweep_sequence_config(sweep_sequence_config),
    .sweep_start_frequency(sweep_start_frequency),
    .point_dwell_time(point_dwell_time),
    .sweep_repeat_count(sweep_repeat_count),
    .return_to_start(return_to_start),
    .hw_trigger_sel(hw_trigger_sel),
    .repeat_forever(repeat_forever),
    .dwell_us_low(dwell_us_low),
    .write_done(write_done)
);

// >>> verif/test_sweep_config_register_writes.sv
`timescale 1ns/1ps
module test_sweep_config_register_writes;
    logic clk = 1'b0; // 250 MHz clock
    logic arst_n = 1'b0; // Reset, active low
    logic [7:0] rx_byte, init_control, system_active_indicator;
    logic [7:0] synthesizer_loop_config, output_tone_or_sweep_select;
    logic [7:0] sweep_sequence_config; // Sweep config
    logic rx_valid, return_to_start, hw_trigger_sel, repeat_forever;
    logic write_done; // Commit pulse
    sweep_pkg::freq_hz_t sweep_start_frequency, sweep_stop_frequency;
    sweep_pkg::freq_hz_t sweep_step_frequency; // Step in Hz
    logic [31:0] point_dwell_time, sweep_repeat_count, dwell_us_low;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0; // Guard against a hang
    always #2 clk = ~clk;
    host_byte_source i_host_byte_source (.clk(clk), .rx_byte(rx_byte),
        .rx_valid(rx_valid));
    sweep_config_register_writes i_sweep_config_register_writes (
        .clk(clk),
        .arst_n(arst_n),
        .rx_byte(rx_byte),
        .rx_valid(rx_valid),
        .init_control(init_control),
        .system_active_indicator(system_active_indicator),
        .synthesizer_loop_config(synthesizer_loop_config),
        .output_tone_or_sweep_select(output_tone_or_sweep_select),
        .sweep_sequence_config(sweep_sequence_config),
        .sweep_start_frequency(sweep_start_frequency),
        .sweep_stop_frequency(sweep_stop_frequency),
        .sweep_step_frequency(sweep_step_frequency),
        .point_dwell_time(point_dwell_time),
        .sweep_repeat_count(sweep_repeat_count),
        .return_to_start(return_to_start),
        .hw_trigger_sel(hw_trigger_sel),
        .repeat_forever(repeat_forever),
        .dwell_us_low(dwell_us_low),
        .write_done(write_done)
    );
    task automatic chk(input string what, input logic [39:0] seen,
                       input logic [39:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d, errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One-byte registers one frame after another, an idle cycle between, then the two config bits
    task automatic t_bytes();
        for (int a = 1; a <= 5; a++) begin
            i_host_byte_source.frame(8'(a), 40'(8'h10 + a), 1);
            chk("write_done", write_done, 1);
        end
        chk("init", init_control, 8'h11);
        chk("active", system_active_indicator, 8'h12);
        chk("loop", synthesizer_loop_config, 8'h13);
        chk("out", output_tone_or_sweep_select, 8'h14);
        chk("hw", hw_trigger_sel, 1);
        chk("ret", return_to_start, 0);
        chk("seq", sweep_sequence_config, 8'h15);
        i_host_byte_source.frame(8'h05, 40'h20, 1);
        chk("hw", hw_trigger_sel, 0);
        chk("ret", return_to_start, 1);
    endtask
    // Five-byte hertz words; start and stop have all lanes distinct
    task automatic t_freq();
        i_host_byte_source.frame(8'h06, 40'hF1_2345_6789, 5);
        i_host_byte_source.frame(8'h07, 40'h0A_BCDE_F012, 5);
        i_host_byte_source.frame(8'h08, 40'h80_0000_0001, 5);
        chk("start", sweep_start_frequency, 40'hF1_2345_6789);
        chk("stop", sweep_stop_frequency, 40'h0A_BCDE_F012);
        chk("step", sweep_step_frequency, 40'h80_0000_0001);
    endtask
    // Four-byte words, dwell scaling and zero count
    task automatic t_word();
        i_host_byte_source.frame(8'h09, 40'h8000_0002, 4);
        i_host_byte_source.frame(8'h0a, 40'h0000_0100, 4);
        chk("dwell", point_dwell_time, 40'h8000_0002);
        // 0x8000_0002 counts of 500 us: the top product bits wrap away
        chk("dwell_us", dwell_us_low, 40'h00_0000_03e8);
        chk("repeat", sweep_repeat_count, 40'h00_0000_0100);
        chk("forever", repeat_forever, 0);
        i_host_byte_source.frame(8'h0a, 40'h0, 4);
        chk("forever", repeat_forever, 1);
    endtask
    // Unknown address swallows its byte; short frame loses framing
    task automatic t_faults();
        i_host_byte_source.frame(8'h20, 40'h01, 1);
        chk("write_done", write_done, 1);
        i_host_byte_source.frame(8'h01, 40'h5A, 1);
        chk("init", init_control, 8'h5A);
        i_host_byte_source.frame(8'h09, 40'h33_2211, 3);
        i_host_byte_source.frame(8'h01, 40'h77, 1);
        chk("dwell", point_dwell_time, 40'h0133_2211);
        chk("init", init_control, 8'h5A);
        i_host_byte_source.put(8'h00);
        i_host_byte_source.frame(8'h01, 40'hC3, 1);
        chk("init", init_control, 8'hC3);
    endtask
    // Reset in mid-frame clears the bank and restores framing
    task automatic t_reset();
        i_host_byte_source.put(8'h06);
        i_host_byte_source.idle();
        arst_n = 1'b0;
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        chk("init", init_control, 8'h00);
        chk("stop", sweep_stop_frequency, 40'h00_0000_0000);
        chk("dwell", point_dwell_time, 40'h00_0000_0000);
        i_host_byte_source.frame(8'h04, 40'h00_0000_0001, 1);
        chk("out", output_tone_or_sweep_select, 8'h01);
        chk("start", sweep_start_frequency, 40'h00_0000_0000);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        chk("start", sweep_start_frequency, 40'h0);
        chk("forever", repeat_forever, 1);
        t_bytes();
        t_freq();
        t_word();
        t_faults();
        t_reset();
        conclude();
    end
endmodule
